// >>> hdl/thm_regs.sv
`default_nettype none
// Contract
// RULE1 - Every register is read and written through the register access port.
// RULE2 - Unused bit positions always read as zero.
// RULE3 - Configuration is one location at 0x03 and 0x09, reset 0x80.
// RULE4 - Sample rate is one location at 0x04 and 0x0a, reset 0x06.
// RULE5 - Internal upper 0x05/0x0b reset 0x55; lower 0x06/0x0c reset zero.
// RULE6 - Remote one upper integer 0x07/0x0d, lower integer 0x08/0x0e shared.
// RULE7 - Any write to 0x0f during standby starts one single update; the code drops a write made in the cycle single_update is high.
// RULE8 - General status 0x02 reports errors, clears on read, resets zero.
// RULE9 - Fault flags 0x1b, one per remote channel, clear on read.
// RULE10 - Channel mask 0x1f selects alarm participation, resets zero.
// RULE11 - One hysteresis value at 0x21 for all critical limits, reset 0x0a.
// RULE12 - Register 0x22 sets consecutive fault count, resets 0x70.
// RULE13 - Critical limits 0x20, 0x19, 0x1a, 0x30 each reset 0x55.
// RULE14 - Results split into read-only integer and fractional bytes.
// RULE15 - Peak integer 0x32 resets 0x80, fraction 0x33, flags 0x34 clear on read.
// RULE16 - Register 0x3a selects channels for peak comparison, resets zero.
// RULE17 - Channel enable 0x3b resets 0x0e or 0x00 by variant.
// RULE18 - Critical flags 0x37 read-only, not cleared by reads.
// RULE19 - Upper flags 0x35 and lower flags 0x36 clear on read, reset zero.
// RULE20 - Gain compensation 0x25 and 0x26 writable, reset 0x08.
// RULE21 - Resistance correction 0x39 and filter 0x40 reset zero.
// RULE22 - Remote limit fractional bytes writable, reset zero.
// RULE23 - Writes to read-only registers ignored; unmapped reads give zero.
module thm_regs
#(
   parameter bit VARIANT_B = 1'b0
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register access
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   // Measurement results
   input wire logic res_load,
   input wire logic [7:0] int_t_int,
   input wire logic [7:0] int_t_frac,
   input wire logic [7:0] r1_t_int,
   input wire logic [7:0] r1_t_frac,
   input wire logic [7:0] r2_t_int,
   input wire logic [7:0] r2_t_frac,
   input wire logic [7:0] r3_t_int,
   input wire logic [7:0] r3_t_frac,
   input wire logic [7:0] peak_int_in,
   input wire logic [7:0] peak_frac_in,
   // Status events and levels
   input wire logic [7:0] status_set,
   input wire logic [7:0] fault_set,
   input wire logic [7:0] peak_set,
   input wire logic [7:0] upper_set,
   input wire logic [7:0] lower_set,
   input wire logic [7:0] crit_level,
   // Settings to the conversion side
   output logic [7:0] general_config,
   output logic [7:0] sample_rate,
   output logic [7:0] internal_upper_bound,
   output logic [7:0] internal_lower_bound,
   output logic [7:0] remote1_upper_bound_int,
   output logic [7:0] remote1_lower_bound_int,
   output logic [7:0] remote1_upper_bound_frac,
   output logic [7:0] remote1_lower_bound_frac,
   output logic [7:0] remote2_upper_bound_int,
   output logic [7:0] remote2_lower_bound_int,
   output logic [7:0] remote2_upper_bound_frac,
   output logic [7:0] remote2_lower_bound_frac,
   output logic [7:0] remote3_upper_bound_int,
   output logic [7:0] remote3_lower_bound_int,
   output logic [7:0] remote3_upper_bound_frac,
   output logic [7:0] remote3_lower_bound_frac,
   output logic [7:0] internal_critical_bound,
   output logic [7:0] remote1_critical_bound,
   output logic [7:0] remote2_critical_bound,
   output logic [7:0] remote3_critical_bound,
   output logic [7:0] alarm_channel_mask,
   output logic [7:0] critical_hysteresis,
   output logic [7:0] fault_queue_depth,
   output logic [7:0] remote1_gain_comp,
   output logic [7:0] remote2_gain_comp,
   output logic [7:0] series_resistance_correction,
   output logic [7:0] peak_channel_select,
   output logic [7:0] channel_enable,
   output logic [7:0] filter_control,
   // One cycle start of a single update
   output logic single_update
);
   typedef struct packed {
      logic [7:0] cfg;
      logic [7:0] rate;
      logic [7:0] int_up;
      logic [7:0] int_lo;
      logic [7:0] r1_up_i;
      logic [7:0] r1_lo_i;
      logic [7:0] r1_up_f;
      logic [7:0] r1_lo_f;
      logic [7:0] r2_up_i;
      logic [7:0] r2_lo_i;
      logic [7:0] r2_up_f;
      logic [7:0] r2_lo_f;
      logic [7:0] r3_up_i;
      logic [7:0] r3_lo_i;
      logic [7:0] r3_up_f;
      logic [7:0] r3_lo_f;
      logic [7:0] int_crit;
      logic [7:0] r1_crit;
      logic [7:0] r2_crit;
      logic [7:0] r3_crit;
      logic [7:0] mask;
      logic [7:0] hyst;
      logic [7:0] queue;
      logic [7:0] r1_gain;
      logic [7:0] r2_gain;
      logic [7:0] src;
      logic [7:0] peak_sel;
      logic [7:0] chan_en;
      logic [7:0] filter;
      logic [7:0] int_ti;
      logic [7:0] int_tf;
      logic [7:0] r1_ti;
      logic [7:0] r1_tf;
      logic [7:0] r2_ti;
      logic [7:0] r2_tf;
      logic [7:0] r3_ti;
      logic [7:0] r3_tf;
      logic [7:0] peak_i;
      logic [7:0] peak_f;
      logic [7:0] crit;
      logic [7:0] rdata;
   } thm_regs_t;

   thm_regs_t q;
   thm_regs_t next_q;
   logic [7:0] status_q;
   logic [7:0] fault_q;
   logic [7:0] peak_flags_q;
   logic [7:0] upper_q;
   logic [7:0] lower_q;

   // Read strobe aimed at one address
   function automatic logic rd_hit(input logic en, input logic [7:0] a, input logic [7:0] t);
      rd_hit = en && (a == t);
   endfunction

   // RULE8 - general status clear on read
   thm_rc_flags u_status
   (
      .clk(clk),
      .rstn(rstn),
      .set(status_set),
      .clr(rd_hit(rd_en, addr, thm_pkg::A_STATUS)),
      .flags(status_q)
   );
   // RULE9 - fault flags clear on read
   thm_rc_flags u_fault
   (
      .clk(clk),
      .rstn(rstn),
      .set(fault_set),
      .clr(rd_hit(rd_en, addr, thm_pkg::A_FAULT)),
      .flags(fault_q)
   );
   // RULE15 - peak flags clear on read
   thm_rc_flags u_peak
   (
      .clk(clk),
      .rstn(rstn),
      .set(peak_set),
      .clr(rd_hit(rd_en, addr, thm_pkg::A_PEAK_FLAGS)),
      .flags(peak_flags_q)
   );
   // RULE19 - upper flags clear on read
   thm_rc_flags u_upper
   (
      .clk(clk),
      .rstn(rstn),
      .set(upper_set),
      .clr(rd_hit(rd_en, addr, thm_pkg::A_UP_FLAGS)),
      .flags(upper_q)
   );
   // RULE19 - lower flags clear on read
   thm_rc_flags u_lower
   (
      .clk(clk),
      .rstn(rstn),
      .set(lower_set),
      .clr(rd_hit(rd_en, addr, thm_pkg::A_LO_FLAGS)),
      .flags(lower_q)
   );
   // RULE7 - trigger gated by standby
   thm_trigger u_trigger
   (
      .clk(clk),
      .rstn(rstn),
      .wr_hit(wr_en && (addr == thm_pkg::A_TRIGGER)),
      .standby(q.cfg[thm_pkg::CFG_STANDBY_BIT]),
      .single_update(single_update)
   );

   always_comb
   begin
      next_q = q;
      // RULE14 - results loaded only by engine
      if (res_load)
      begin
         next_q.int_ti = int_t_int;
         next_q.int_tf = int_t_frac;
         next_q.r1_ti = r1_t_int;
         next_q.r1_tf = r1_t_frac;
         next_q.r2_ti = r2_t_int;
         next_q.r2_tf = r2_t_frac;
         next_q.r3_ti = r3_t_int;
         next_q.r3_tf = r3_t_frac;
         next_q.peak_i = peak_int_in;
         next_q.peak_f = peak_frac_in;
      end
      // RULE18 - critical flags follow the level
      next_q.crit = crit_level;
      // RULE1 - register write decode
      if (wr_en)
      begin
         unique case (addr)
            // RULE3 - one config location
            thm_pkg::A_CFG, thm_pkg::A_CFG_M: next_q.cfg = wdata;
            // RULE4 - one rate location
            thm_pkg::A_RATE, thm_pkg::A_RATE_M: next_q.rate = wdata;
            // RULE5 - internal limits mirrored
            thm_pkg::A_INT_UP, thm_pkg::A_INT_UP_M: next_q.int_up = wdata;
            thm_pkg::A_INT_LO, thm_pkg::A_INT_LO_M: next_q.int_lo = wdata;
            // RULE6 - remote one limits mirrored
            thm_pkg::A_R1_UP_I, thm_pkg::A_R1_UP_I_M: next_q.r1_up_i = wdata;
            thm_pkg::A_R1_LO_I, thm_pkg::A_R1_LO_I_M: next_q.r1_lo_i = wdata;
            // RULE22 - fractional limit bytes, with remote two and three integer limits
            thm_pkg::A_R1_UP_F: next_q.r1_up_f = wdata;
            thm_pkg::A_R1_LO_F: next_q.r1_lo_f = wdata;
            thm_pkg::A_R2_UP_I: next_q.r2_up_i = wdata;
            thm_pkg::A_R2_LO_I: next_q.r2_lo_i = wdata;
            thm_pkg::A_R2_UP_F: next_q.r2_up_f = wdata;
            thm_pkg::A_R2_LO_F: next_q.r2_lo_f = wdata;
            thm_pkg::A_R3_UP_I: next_q.r3_up_i = wdata;
            thm_pkg::A_R3_LO_I: next_q.r3_lo_i = wdata;
            thm_pkg::A_R3_UP_F: next_q.r3_up_f = wdata;
            thm_pkg::A_R3_LO_F: next_q.r3_lo_f = wdata;
            // RULE13 - critical limits
            thm_pkg::A_INT_CRIT: next_q.int_crit = wdata;
            thm_pkg::A_R1_CRIT: next_q.r1_crit = wdata;
            thm_pkg::A_R2_CRIT: next_q.r2_crit = wdata;
            thm_pkg::A_R3_CRIT: next_q.r3_crit = wdata;
            // RULE10 - channel mask
            thm_pkg::A_MASK: next_q.mask = wdata;
            // RULE11 - shared hysteresis
            thm_pkg::A_HYST: next_q.hyst = wdata;
            // RULE12 - fault queue depth
            thm_pkg::A_QUEUE: next_q.queue = wdata;
            // RULE20 - gain compensation
            thm_pkg::A_R1_GAIN: next_q.r1_gain = wdata;
            thm_pkg::A_R2_GAIN: next_q.r2_gain = wdata;
            // RULE21 - correction and filter
            thm_pkg::A_SRC: next_q.src = wdata;
            thm_pkg::A_FILTER: next_q.filter = wdata;
            // RULE16 - peak channel select
            thm_pkg::A_PEAK_SEL: next_q.peak_sel = wdata;
            // RULE17 - channel enables
            thm_pkg::A_CHAN_EN: next_q.chan_en = wdata;
            // RULE23 - read-only targets ignored
            default: next_q.cfg = q.cfg;
         endcase
      end
      // RULE1 - register read mux
      if (rd_en)
      begin
         unique case (addr)
            thm_pkg::A_INT_T_INT: next_q.rdata = q.int_ti;
            thm_pkg::A_INT_T_FRAC: next_q.rdata = q.int_tf;
            thm_pkg::A_R1_T_INT: next_q.rdata = q.r1_ti;
            thm_pkg::A_R1_T_FRAC: next_q.rdata = q.r1_tf;
            thm_pkg::A_R2_T_INT: next_q.rdata = q.r2_ti;
            thm_pkg::A_R2_T_FRAC: next_q.rdata = q.r2_tf;
            thm_pkg::A_R3_T_INT: next_q.rdata = q.r3_ti;
            thm_pkg::A_R3_T_FRAC: next_q.rdata = q.r3_tf;
            thm_pkg::A_STATUS: next_q.rdata = status_q;
            thm_pkg::A_CFG, thm_pkg::A_CFG_M: next_q.rdata = q.cfg;
            thm_pkg::A_RATE, thm_pkg::A_RATE_M: next_q.rdata = q.rate;
            thm_pkg::A_INT_UP, thm_pkg::A_INT_UP_M: next_q.rdata = q.int_up;
            thm_pkg::A_INT_LO, thm_pkg::A_INT_LO_M: next_q.rdata = q.int_lo;
            thm_pkg::A_R1_UP_I, thm_pkg::A_R1_UP_I_M: next_q.rdata = q.r1_up_i;
            thm_pkg::A_R1_LO_I, thm_pkg::A_R1_LO_I_M: next_q.rdata = q.r1_lo_i;
            thm_pkg::A_R1_UP_F: next_q.rdata = q.r1_up_f;
            thm_pkg::A_R1_LO_F: next_q.rdata = q.r1_lo_f;
            thm_pkg::A_R2_UP_I: next_q.rdata = q.r2_up_i;
            thm_pkg::A_R2_LO_I: next_q.rdata = q.r2_lo_i;
            thm_pkg::A_R2_UP_F: next_q.rdata = q.r2_up_f;
            thm_pkg::A_R2_LO_F: next_q.rdata = q.r2_lo_f;
            thm_pkg::A_R3_UP_I: next_q.rdata = q.r3_up_i;
            thm_pkg::A_R3_LO_I: next_q.rdata = q.r3_lo_i;
            thm_pkg::A_R3_UP_F: next_q.rdata = q.r3_up_f;
            thm_pkg::A_R3_LO_F: next_q.rdata = q.r3_lo_f;
            thm_pkg::A_INT_CRIT: next_q.rdata = q.int_crit;
            thm_pkg::A_R1_CRIT: next_q.rdata = q.r1_crit;
            thm_pkg::A_R2_CRIT: next_q.rdata = q.r2_crit;
            thm_pkg::A_R3_CRIT: next_q.rdata = q.r3_crit;
            thm_pkg::A_FAULT: next_q.rdata = fault_q;
            thm_pkg::A_MASK: next_q.rdata = q.mask;
            thm_pkg::A_HYST: next_q.rdata = q.hyst;
            thm_pkg::A_QUEUE: next_q.rdata = q.queue;
            thm_pkg::A_R1_GAIN: next_q.rdata = q.r1_gain;
            thm_pkg::A_R2_GAIN: next_q.rdata = q.r2_gain;
            // RULE15 - peak result bytes
            thm_pkg::A_PEAK_INT: next_q.rdata = q.peak_i;
            thm_pkg::A_PEAK_FRAC: next_q.rdata = q.peak_f;
            thm_pkg::A_PEAK_FLAGS: next_q.rdata = peak_flags_q;
            thm_pkg::A_UP_FLAGS: next_q.rdata = upper_q;
            thm_pkg::A_LO_FLAGS: next_q.rdata = lower_q;
            // RULE18 - not cleared by reading
            thm_pkg::A_CRIT_FLAGS: next_q.rdata = q.crit;
            thm_pkg::A_SRC: next_q.rdata = q.src;
            thm_pkg::A_PEAK_SEL: next_q.rdata = q.peak_sel;
            thm_pkg::A_CHAN_EN: next_q.rdata = q.chan_en;
            thm_pkg::A_FILTER: next_q.rdata = q.filter;
            // RULE2 - unused bits and trigger read zero
            // RULE23 - unmapped reads return zero
            default: next_q.rdata = thm_pkg::R_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         q <= '0;
         q.cfg <= thm_pkg::R_CFG;
         q.rate <= thm_pkg::R_RATE;
         q.int_up <= thm_pkg::R_UPPER;
         q.r1_up_i <= thm_pkg::R_UPPER;
         q.r2_up_i <= thm_pkg::R_UPPER;
         q.r3_up_i <= thm_pkg::R_UPPER;
         q.int_crit <= thm_pkg::R_CRIT;
         q.r1_crit <= thm_pkg::R_CRIT;
         q.r2_crit <= thm_pkg::R_CRIT;
         q.r3_crit <= thm_pkg::R_CRIT;
         q.hyst <= thm_pkg::R_HYST;
         q.queue <= thm_pkg::R_QUEUE;
         q.r1_gain <= thm_pkg::R_GAIN;
         q.r2_gain <= thm_pkg::R_GAIN;
         q.peak_i <= thm_pkg::R_PEAK_INT;
         // Variant fixed at build time, so a constant under reset
         q.chan_en <= VARIANT_B ? thm_pkg::R_CHAN_EN_B : thm_pkg::R_CHAN_EN_A;
      end
      else
      begin
         q <= next_q;
      end
   end

   // Outputs straight from the state flops
   assign rdata = q.rdata;
   assign general_config = q.cfg;
   assign sample_rate = q.rate;
   assign internal_upper_bound = q.int_up;
   assign internal_lower_bound = q.int_lo;
   assign remote1_upper_bound_int = q.r1_up_i;
   assign remote1_lower_bound_int = q.r1_lo_i;
   assign remote1_upper_bound_frac = q.r1_up_f;
   assign remote1_lower_bound_frac = q.r1_lo_f;
   assign remote2_upper_bound_int = q.r2_up_i;
   assign remote2_lower_bound_int = q.r2_lo_i;
   assign remote2_upper_bound_frac = q.r2_up_f;
   assign remote2_lower_bound_frac = q.r2_lo_f;
   assign remote3_upper_bound_int = q.r3_up_i;
   assign remote3_lower_bound_int = q.r3_lo_i;
   assign remote3_upper_bound_frac = q.r3_up_f;
   assign remote3_lower_bound_frac = q.r3_lo_f;
   assign internal_critical_bound = q.int_crit;
   assign remote1_critical_bound = q.r1_crit;
   assign remote2_critical_bound = q.r2_crit;
   assign remote3_critical_bound = q.r3_crit;
   assign alarm_channel_mask = q.mask;
   assign critical_hysteresis = q.hyst;
   assign fault_queue_depth = q.queue;
   assign remote1_gain_comp = q.r1_gain;
   assign remote2_gain_comp = q.r2_gain;
   assign series_resistance_correction = q.src;
   assign peak_channel_select = q.peak_sel;
   assign channel_enable = q.chan_en;
   assign filter_control = q.filter;
endmodule
`default_nettype wire

// >>> include/thm_pkg.sv
`default_nettype none
package thm_pkg;
   // Register offsets
   localparam logic [7:0] A_INT_T_INT = 8'h00;
   localparam logic [7:0] A_R1_T_INT = 8'h01;
   localparam logic [7:0] A_STATUS = 8'h02;
   localparam logic [7:0] A_CFG = 8'h03;
   localparam logic [7:0] A_RATE = 8'h04;
   localparam logic [7:0] A_INT_UP = 8'h05;
   localparam logic [7:0] A_INT_LO = 8'h06;
   localparam logic [7:0] A_R1_UP_I = 8'h07;
   localparam logic [7:0] A_R1_LO_I = 8'h08;
   localparam logic [7:0] A_CFG_M = 8'h09;
   localparam logic [7:0] A_RATE_M = 8'h0a;
   localparam logic [7:0] A_INT_UP_M = 8'h0b;
   localparam logic [7:0] A_INT_LO_M = 8'h0c;
   localparam logic [7:0] A_R1_UP_I_M = 8'h0d;
   localparam logic [7:0] A_R1_LO_I_M = 8'h0e;
   localparam logic [7:0] A_TRIGGER = 8'h0f;
   localparam logic [7:0] A_R1_T_FRAC = 8'h10;
   localparam logic [7:0] A_R1_UP_F = 8'h13;
   localparam logic [7:0] A_R1_LO_F = 8'h14;
   localparam logic [7:0] A_R2_UP_I = 8'h15;
   localparam logic [7:0] A_R2_LO_I = 8'h16;
   localparam logic [7:0] A_R2_UP_F = 8'h17;
   localparam logic [7:0] A_R2_LO_F = 8'h18;
   localparam logic [7:0] A_R1_CRIT = 8'h19;
   localparam logic [7:0] A_R2_CRIT = 8'h1a;
   localparam logic [7:0] A_FAULT = 8'h1b;
   localparam logic [7:0] A_MASK = 8'h1f;
   localparam logic [7:0] A_INT_CRIT = 8'h20;
   localparam logic [7:0] A_HYST = 8'h21;
   localparam logic [7:0] A_QUEUE = 8'h22;
   localparam logic [7:0] A_R2_T_INT = 8'h23;
   localparam logic [7:0] A_R2_T_FRAC = 8'h24;
   localparam logic [7:0] A_R1_GAIN = 8'h25;
   localparam logic [7:0] A_R2_GAIN = 8'h26;
   localparam logic [7:0] A_INT_T_FRAC = 8'h29;
   localparam logic [7:0] A_R3_T_INT = 8'h2a;
   localparam logic [7:0] A_R3_T_FRAC = 8'h2b;
   localparam logic [7:0] A_R3_UP_I = 8'h2c;
   localparam logic [7:0] A_R3_LO_I = 8'h2d;
   localparam logic [7:0] A_R3_UP_F = 8'h2e;
   localparam logic [7:0] A_R3_LO_F = 8'h2f;
   localparam logic [7:0] A_R3_CRIT = 8'h30;
   localparam logic [7:0] A_PEAK_INT = 8'h32;
   localparam logic [7:0] A_PEAK_FRAC = 8'h33;
   localparam logic [7:0] A_PEAK_FLAGS = 8'h34;
   localparam logic [7:0] A_UP_FLAGS = 8'h35;
   localparam logic [7:0] A_LO_FLAGS = 8'h36;
   localparam logic [7:0] A_CRIT_FLAGS = 8'h37;
   localparam logic [7:0] A_SRC = 8'h39;
   localparam logic [7:0] A_PEAK_SEL = 8'h3a;
   localparam logic [7:0] A_CHAN_EN = 8'h3b;
   localparam logic [7:0] A_FILTER = 8'h40;
   // Values after reset
   localparam logic [7:0] R_ZERO = 8'h00;
   localparam logic [7:0] R_CFG = 8'h80;
   localparam logic [7:0] R_RATE = 8'h06;
   localparam logic [7:0] R_UPPER = 8'h55;
   localparam logic [7:0] R_CRIT = 8'h55;
   localparam logic [7:0] R_HYST = 8'h0a;
   localparam logic [7:0] R_QUEUE = 8'h70;
   localparam logic [7:0] R_GAIN = 8'h08;
   localparam logic [7:0] R_PEAK_INT = 8'h80;
   localparam logic [7:0] R_CHAN_EN_A = 8'h0e;
   localparam logic [7:0] R_CHAN_EN_B = 8'h00;
   // Field position
   localparam int CFG_STANDBY_BIT = 6;
   typedef enum logic [1:0] {TRG_IDLE = 2'b01, TRG_FIRE = 2'b10} thm_trg_t;
endpackage
`default_nettype wire

// >>> hdl/thm_rc_flags.sv
`default_nettype none
module thm_rc_flags
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Events and clear
   input wire logic [7:0] set,
   input wire logic clr,
   // Flags
   output logic [7:0] flags
);
   typedef struct packed {
      logic [7:0] flags;
   } thm_rc_t;
   thm_rc_t q;
   thm_rc_t next_q;
   // Set beats a clear in the same cycle, no event lost
   always_comb
   begin
      next_q = q;
      next_q.flags = (q.flags & ~{8{clr}}) | set;
   end
   always_ff @(posedge clk)
   begin
      if (!rstn)
         q <= '0;
      else
         q <= next_q;
   end
   assign flags = q.flags;
endmodule
`default_nettype wire

// >>> hdl/thm_trigger.sv
`default_nettype none
module thm_trigger
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Trigger write and mode
   input wire logic wr_hit,
   input wire logic standby,
   // One cycle start
   output logic single_update
);
   typedef struct packed {
      thm_pkg::thm_trg_t st;
   } thm_trg_s_t;
   thm_trg_s_t q;
   thm_trg_s_t next_q;
   always_comb
   begin
      next_q = q;
      unique case (q.st)
         thm_pkg::TRG_IDLE:
         begin
            // RULE7 - standby write fires
            if (wr_hit && standby)
               next_q.st = thm_pkg::TRG_FIRE;
         end
         thm_pkg::TRG_FIRE:
         begin
            next_q.st = thm_pkg::TRG_IDLE;
         end
         default:
         begin
            next_q.st = thm_pkg::TRG_IDLE;
         end
      endcase
   end
   always_ff @(posedge clk)
   begin
      if (!rstn)
         q.st <= thm_pkg::TRG_IDLE;
      else
         q <= next_q;
   end
   // Writes outside standby or while single_update is high are dropped on purpose
   assign single_update = q.st[1];
endmodule
`default_nettype wire

// >>> verif/thm_regs_sva.sv
`default_nettype none
module thm_regs_sva
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register access
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   // Levels and settings
   input wire logic [7:0] crit_level,
   input wire logic [7:0] general_config,
   input wire logic [7:0] sample_rate,
   input wire logic [7:0] internal_upper_bound,
   input wire logic [7:0] critical_hysteresis,
   input wire logic single_update
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   logic trig_q;
   // Trigger during a running pulse is dropped
   always_ff @(posedge clk)
      trig_q <= wr_en && addr == 8'h0f && general_config[6] && !single_update;
   sequence s_fire;
      wr_en && addr == 8'h0f && general_config[6] && !single_update;
   endsequence
   sequence s_pulse;
      single_update ##1 !single_update;
   endsequence
   a_trig_pulse: assert property (s_fire |=> s_pulse)
      else $error("one shot pulse missing");
   a_trig_cause: assert property (single_update |-> trig_q)
      else $error("one shot pulse without trigger");
   a_cfg_write: assert property (wr_en && (addr == 8'h03 || addr == 8'h09) |=>
      general_config == $past(wdata)) else $error("config write lost");
   a_rate_write: assert property (wr_en && (addr == 8'h04 || addr == 8'h0a) |=>
      sample_rate == $past(wdata)) else $error("rate write lost");
   a_cfg_mirror: assert property (rd_en && addr == 8'h09 |=>
      rdata == $past(general_config)) else $error("config mirror read wrong");
   a_wo_unmapped: assert property (rd_en && (addr == 8'h0f || addr > 8'h40) |=>
      rdata == 8'h00) else $error("unmapped read not zero");
   a_crit_read: assert property ($past(rstn) && rd_en && addr == 8'h37 &&
      $stable(crit_level) |=> rdata == $past(crit_level)) else $error("crit flags read wrong");
   a_rdata_hold: assert property (!rd_en |=> $stable(rdata))
      else $error("read data moved without read");
   a_reset_vals: assert property ($rose(rstn) |-> critical_hysteresis == 8'h0a &&
      internal_upper_bound == 8'h55 && sample_rate == 8'h06) else $error("reset value wrong");
endmodule
bind thm_regs thm_regs_sva u_sva (.clk(clk), .rstn(rstn), .wr_en(wr_en), .rd_en(rd_en),
   .addr(addr), .wdata(wdata), .rdata(rdata), .crit_level(crit_level),
   .general_config(general_config), .sample_rate(sample_rate),
   .internal_upper_bound(internal_upper_bound), .critical_hysteresis(critical_hysteresis),
   .single_update(single_update));
`default_nettype wire

// >>> verif/thm_host.sv
`default_nettype none
module thm_host
(
   // Clock
   input wire logic clk,
   // Register access
   output logic wr_en,
   output logic rd_en,
   output logic [7:0] addr,
   output logic [7:0] wdata,
   input wire logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      wr_en = 1'h0;
      rd_en = 1'h0;
      addr = 8'h00;
      wdata = 8'h00;
   end
   task wr(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_en <= 1'h1;
      @(posedge clk);
      wr_en <= 1'h0;
      // Released lines inverted so stale values never pass
      addr <= ~a;
      wdata <= ~d;
      @(posedge clk);
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      addr <= a;
      rd_en <= 1'h1;
      @(posedge clk);
      rd_en <= 1'h0;
      addr <= ~a;
      @(posedge clk);
      d = rdata;
   endtask
endmodule
`default_nettype wire

// >>> verif/thm_regs_tb.sv
`default_nettype none
module thm_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [7:0] wa; logic [7:0] ra; logic [7:0] d; logic [7:0] e;} thm_row_t;
   logic clk = 1'h0;
   logic rstn = 1'h0;
   logic res_load = 1'h0;
   logic wr_en, rd_en, single_update;
   logic [7:0] addr, wdata, rdata, got;
   logic [7:0] crit_level = 8'h00;
   logic [7:0] ev [5] = '{default: 8'h00};
   logic [7:0] res [10] = '{default: 8'h00};
   logic [7:0] ra [10] = '{8'h00, 8'h29, 8'h01, 8'h10, 8'h23, 8'h24, 8'h2a, 8'h2b, 8'h32, 8'h33};
   logic [7:0] cor [5] = '{8'h02, 8'h1b, 8'h34, 8'h35, 8'h36};
   int fail_count = 0;
   int num_checks = 0;
   int pulses = 0;
   // Write address ff is unmapped, so reset rows write harmlessly
   thm_row_t rows [17] = '{
      '{8'hff, 8'h03, 8'h00, 8'h80}, '{8'hff, 8'h0a, 8'h00, 8'h06},
      '{8'hff, 8'h0b, 8'h00, 8'h55}, '{8'hff, 8'h0d, 8'h00, 8'h55},
      '{8'hff, 8'h20, 8'h00, 8'h55}, '{8'hff, 8'h21, 8'h00, 8'h0a},
      '{8'hff, 8'h22, 8'h00, 8'h70}, '{8'hff, 8'h32, 8'h00, 8'h80},
      '{8'hff, 8'h26, 8'h00, 8'h08}, '{8'hff, 8'h3b, 8'h00, 8'h0e},
      '{8'hff, 8'h1f, 8'h00, 8'h00}, '{8'h03, 8'h09, 8'h81, 8'h81},
      '{8'h0a, 8'h04, 8'h03, 8'h03}, '{8'h0e, 8'h08, 8'h12, 8'h12},
      '{8'h17, 8'h17, 8'ha5, 8'ha5}, '{8'h40, 8'h40, 8'h3c, 8'h3c},
      '{8'h37, 8'h41, 8'hff, 8'h00}};
   always #50 clk = ~clk;
   always @(posedge clk)
      if (single_update === 1'h1)
         pulses++;
   thm_host host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
      .rdata(rdata));
   thm_regs #(.VARIANT_B(1'h0)) dut (.clk(clk), .rstn(rstn), .wr_en(wr_en), .rd_en(rd_en),
      .addr(addr), .wdata(wdata), .rdata(rdata), .res_load(res_load), .int_t_int(res[0]),
      .int_t_frac(res[1]), .r1_t_int(res[2]), .r1_t_frac(res[3]), .r2_t_int(res[4]),
      .r2_t_frac(res[5]), .r3_t_int(res[6]), .r3_t_frac(res[7]), .peak_int_in(res[8]),
      .peak_frac_in(res[9]), .status_set(ev[0]), .fault_set(ev[1]), .peak_set(ev[2]),
      .upper_set(ev[3]), .lower_set(ev[4]), .crit_level(crit_level), .general_config(),
      .sample_rate(), .internal_upper_bound(), .internal_lower_bound(),
      .remote1_upper_bound_int(), .remote1_lower_bound_int(), .remote1_upper_bound_frac(),
      .remote1_lower_bound_frac(), .remote2_upper_bound_int(), .remote2_lower_bound_int(),
      .remote2_upper_bound_frac(), .remote2_lower_bound_frac(), .remote3_upper_bound_int(),
      .remote3_lower_bound_int(), .remote3_upper_bound_frac(), .remote3_lower_bound_frac(),
      .internal_critical_bound(), .remote1_critical_bound(), .remote2_critical_bound(),
      .remote3_critical_bound(), .alarm_channel_mask(), .critical_hysteresis(),
      .fault_queue_depth(), .remote1_gain_comp(), .remote2_gain_comp(),
      .series_resistance_correction(), .peak_channel_select(), .channel_enable(),
      .filter_control(), .single_update(single_update));
   task chk(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task results;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      repeat (2000) @(posedge clk);
      fail_count++;
      results;
   end
   initial
   begin
      repeat (4) @(posedge clk);
      rstn <= 1'h1;
      @(posedge clk);
      foreach (rows[i])
      begin
         host.wr(rows[i].wa, rows[i].d);
         host.rd(rows[i].ra, got);
         chk(got, rows[i].e);
      end
      foreach (res[i])
         res[i] <= 8'h10 + 8'(i);
      res_load <= 1'h1;
      @(posedge clk);
      res_load <= 1'h0;
      // Write to a result byte must not stick
      host.wr(8'h00, 8'hff);
      foreach (ra[i])
      begin
         host.rd(ra[i], got);
         chk(got, 8'h10 + 8'(i));
      end
      foreach (cor[i])
      begin
         ev[i] <= 8'h06;
         @(posedge clk);
         ev[i] <= 8'h00;
         host.rd(cor[i], got);
         chk(got, 8'h06);
         host.rd(cor[i], got);
         chk(got, 8'h00);
      end
      crit_level <= 8'h0b;
      repeat (2) @(posedge clk);
      host.rd(8'h37, got);
      chk(got, 8'h0b);
      host.rd(8'h37, got);
      chk(got, 8'h0b);
      // Trigger outside standby first, then in standby
      host.wr(8'h0f, 8'h5a);
      host.wr(8'h09, 8'h40);
      host.wr(8'h0f, 8'h00);
      repeat (2) @(posedge clk);
      chk(8'(pulses), 8'h01);
      rstn <= 1'h0;
      repeat (4) @(posedge clk);
      rstn <= 1'h1;
      host.rd(8'h03, got);
      chk(got, 8'h80);
      results;
   end
endmodule
`default_nettype wire
